// *** hdl/dcc_pkg.sv ***
package dcc_pkg;
    localparam logic [7:0] OFS_SAWTOOTH_DIVIDER = 8'h03;
    localparam logic [7:0] OFS_TEST = 8'h04;
    localparam logic [7:0] OFS_EQ = 8'h05;
    localparam logic [7:0] OFS_SRC_A = 8'h09;
    localparam logic [7:0] OFS_DST_A = 8'h0A;
    localparam logic [7:0] OFS_SRC_B = 8'h0B;
    localparam logic [7:0] OFS_DST_B = 8'h0C;
    localparam logic [7:0] OFS_RATE = 8'h0D;
    localparam logic [7:0] OFS_INPUT = 8'h0E;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_EQ = 8'h09;
    localparam int CHK_BIT = 5;
    localparam int EQ_EN_BIT = 4;
    localparam int GPI_BIT = 4;
    localparam logic [3:0] EQ_MAX = 4'hB;
    localparam logic [1:0] SS_TWO = 2'h1;
    localparam logic [1:0] SS_FOUR = 2'h3;
    localparam logic [5:0] SAWTOOTH_DIVIDER_MAX_TWO = 6'h1E;
    localparam logic [5:0] SAWTOOTH_DIVIDER_MAX_FOUR = 6'h0F;
    localparam logic [7:0] MOD_COEF = 8'hD0;
    localparam logic [5:0] AUTO_DIV0 = 6'h02;
    localparam logic [5:0] AUTO_DIV1 = 6'h04;
    localparam logic [5:0] AUTO_DIV2 = 6'h08;
    localparam logic [5:0] AUTO_DIV3 = 6'h0F;
    localparam logic [11:0] HALF_SLOW = 12'h07D0;
endpackage : dcc_pkg

// *** hdl/dcc_top.sv ***
`timescale 1ns/1ps
module dcc_top
    import dcc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Register port from the control-channel slave
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Forwarding toward the remote side
    input wire logic fwd_addr_valid_in,
    input wire logic [7:0] fwd_addr_in,
    input wire logic remote_done_in,
    output logic local_scl_out,
    output logic local_scl_oe_out,
    output logic remote_req_out,
    output logic [7:0] remote_addr_out,
    output logic remote_scl_out,
    // Input relay
    input wire logic relay_input_in,
    output logic relay_level_out,
    output logic relay_strobe_out,
    // Pixel clock status
    input wire logic data_rate_select_in,
    input wire logic [1:0] pclk_range_in,
    // Link and output controls
    output logic checker_en_out,
    output logic eq_en_out,
    output logic [3:0] eq_boost_out,
    output logic spread_on_out,
    output logic spread_wide_out,
    output logic [5:0] sawtooth_div_out,
    output logic mod_tick_out
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_STRETCH = 2'b10
    } dcc_state_t;

    function automatic logic [7:0] xlate(input logic [7:0] a, input logic [7:0] sa,
        input logic [7:0] da, input logic [7:0] sb, input logic [7:0] db);
        logic [7:0] r;
        r = a;
        if (a[7:1] == sa[7:1]) begin
            r = {da[7:1], a[0]};
        end else if (a[7:1] == sb[7:1]) begin
            r = {db[7:1], a[0]};
        end
        return r;
    endfunction : xlate

    logic [7:0] sawtooth_divider_reg, test_reg, eq_reg, src_a, dst_a, src_b, dst_b, rate_reg;
    logic [7:0] next_sawtooth_divider_reg, next_test_reg, next_eq_reg, next_src_a, next_dst_a;
    logic [7:0] next_src_b, next_dst_b, next_rate_reg, next_rdata;
    logic gpi_s1, gpi_s2, gpi_s3;
    logic next_level, next_strobe;
    dcc_state_t state, next_state;
    logic [7:0] next_raddr;
    logic [11:0] scl_cnt, next_scl_cnt;
    logic next_scl;
    logic [5:0] div_eff;
    logic [1:0] ss;
    logic next_tick;
    logic [13:0] mod_cnt, next_mod_cnt, mod_lim;

    // Register file.
    always_comb begin
        next_sawtooth_divider_reg = sawtooth_divider_reg;
        next_test_reg = test_reg;
        next_eq_reg = eq_reg;
        next_src_a = src_a;
        next_dst_a = dst_a;
        next_src_b = src_b;
        next_dst_b = dst_b;
        next_rate_reg = rate_reg;
        if (reg_wr_in) begin
            if (reg_addr_in == OFS_SAWTOOTH_DIVIDER) begin
                next_sawtooth_divider_reg = reg_wdata_in;
            end else if (reg_addr_in == OFS_TEST) begin
                next_test_reg = reg_wdata_in;
            end else if (reg_addr_in == OFS_EQ) begin
                next_eq_reg = reg_wdata_in;
            end else if (reg_addr_in == OFS_SRC_A) begin
                next_src_a = reg_wdata_in;
            end else if (reg_addr_in == OFS_DST_A) begin
                next_dst_a = reg_wdata_in;
            end else if (reg_addr_in == OFS_SRC_B) begin
                next_src_b = reg_wdata_in;
            end else if (reg_addr_in == OFS_DST_B) begin
                next_dst_b = reg_wdata_in;
            end else if (reg_addr_in == OFS_RATE) begin
                next_rate_reg = reg_wdata_in;
            end
        end
        next_rdata = reg_rdata_out;
        if (reg_rd_in) begin
            if (reg_addr_in == OFS_SAWTOOTH_DIVIDER) begin
                next_rdata = sawtooth_divider_reg;
            end else if (reg_addr_in == OFS_TEST) begin
                next_rdata = test_reg;
            end else if (reg_addr_in == OFS_EQ) begin
                next_rdata = eq_reg;
            end else if (reg_addr_in == OFS_SRC_A) begin
                next_rdata = src_a;
            end else if (reg_addr_in == OFS_DST_A) begin
                next_rdata = dst_a;
            end else if (reg_addr_in == OFS_SRC_B) begin
                next_rdata = src_b;
            end else if (reg_addr_in == OFS_DST_B) begin
                next_rdata = dst_b;
            end else if (reg_addr_in == OFS_RATE) begin
                next_rdata = rate_reg;
            end else if (reg_addr_in == OFS_INPUT) begin
                next_rdata = RST_ZERO;
                next_rdata[GPI_BIT] = gpi_s2;
            end else begin
                next_rdata = RST_ZERO;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sawtooth_divider_reg <= RST_ZERO;
            test_reg <= RST_ZERO;
            eq_reg <= RST_EQ;
            src_a <= RST_ZERO;
            dst_a <= RST_ZERO;
            src_b <= RST_ZERO;
            dst_b <= RST_ZERO;
            rate_reg <= RST_ZERO;
            reg_rdata_out <= RST_ZERO;
        end else begin
            sawtooth_divider_reg <= next_sawtooth_divider_reg;
            test_reg <= next_test_reg;
            eq_reg <= next_eq_reg;
            src_a <= next_src_a;
            dst_a <= next_dst_a;
            src_b <= next_src_b;
            dst_b <= next_dst_b;
            rate_reg <= next_rate_reg;
            reg_rdata_out <= next_rdata;
        end
    end

    assign checker_en_out = test_reg[CHK_BIT];
    assign eq_en_out = eq_reg[EQ_EN_BIT];
    // Codes above the top level are clamped so the analog stage never sees them.
    assign eq_boost_out = (eq_reg[3:0] > EQ_MAX) ? EQ_MAX : eq_reg[3:0];

    // Forwarding with clock stretch; a second request while busy is dropped.
    always_comb begin
        next_state = state;
        next_raddr = remote_addr_out;
        next_scl_cnt = scl_cnt;
        next_scl = remote_scl_out;
        case (state)
            ST_IDLE: begin
                next_scl = 1'b1;
                if (fwd_addr_valid_in) begin
                    next_raddr = xlate(fwd_addr_in, src_a, dst_a, src_b, dst_b);
                    next_scl_cnt = HALF_SLOW >> rate_reg[2:0];
                    next_state = ST_STRETCH;
                end
            end
            ST_STRETCH: begin
                if (scl_cnt == 12'h0000) begin
                    next_scl_cnt = HALF_SLOW >> rate_reg[2:0];
                    next_scl = ~remote_scl_out;
                end else begin
                    next_scl_cnt = scl_cnt - 12'h0001;
                end
                if (remote_done_in) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
            remote_addr_out <= RST_ZERO;
            scl_cnt <= 12'h0000;
            remote_scl_out <= 1'b1;
        end else begin
            state <= next_state;
            remote_addr_out <= next_raddr;
            scl_cnt <= next_scl_cnt;
            remote_scl_out <= next_scl;
        end
    end

    assign local_scl_out = 1'b0;
    assign local_scl_oe_out = (state == ST_STRETCH);
    assign remote_req_out = (state == ST_STRETCH);

    // Input relay; the pin is synchronised before use.
    always_comb begin
        next_level = relay_level_out;
        next_strobe = 1'b0;
        if (gpi_s3 != gpi_s2) begin
            next_level = gpi_s2;
            next_strobe = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            gpi_s1 <= 1'b0;
            gpi_s2 <= 1'b0;
            gpi_s3 <= 1'b0;
            relay_level_out <= 1'b0;
            relay_strobe_out <= 1'b0;
        end else begin
            gpi_s1 <= relay_input_in;
            gpi_s2 <= gpi_s1;
            gpi_s3 <= gpi_s2;
            relay_level_out <= next_level;
            relay_strobe_out <= next_strobe;
        end
    end

    // Spread decode and sawtooth divider; zero in the divider field means automatic.
    assign ss = sawtooth_divider_reg[7:6];
    assign spread_on_out = (ss == SS_TWO) || (ss == SS_FOUR);
    assign spread_wide_out = (ss == SS_FOUR);
    always_comb begin
        div_eff = sawtooth_divider_reg[5:0];
        if (sawtooth_divider_reg[5:0] == 6'h00) begin
            case (pclk_range_in)
                2'h0: div_eff = AUTO_DIV0;
                2'h1: div_eff = AUTO_DIV1;
                2'h2: div_eff = AUTO_DIV2;
                default: div_eff = AUTO_DIV3;
            endcase
            if (!spread_wide_out && div_eff > SAWTOOTH_DIVIDER_MAX_TWO) begin
                div_eff = SAWTOOTH_DIVIDER_MAX_TWO;
            end else if (spread_wide_out && div_eff > SAWTOOTH_DIVIDER_MAX_FOUR) begin
                div_eff = SAWTOOTH_DIVIDER_MAX_FOUR;
            end
        end
    end
    assign sawtooth_div_out = div_eff;

    // Double rate halves the period, matching the doubled modulation rate.
    assign mod_lim = 14'(({6'h00, MOD_COEF} * {8'h00, div_eff}) >> data_rate_select_in);
    always_comb begin
        next_mod_cnt = 14'h0000;
        next_tick = 1'b0;
        if (spread_on_out) begin
            if (mod_cnt >= mod_lim - 14'h0001) begin
                next_tick = 1'b1;
            end else begin
                next_mod_cnt = mod_cnt + 14'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            mod_cnt <= 14'h0000;
            mod_tick_out <= 1'b0;
        end else begin
            mod_cnt <= next_mod_cnt;
            mod_tick_out <= next_tick;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // Registered outputs are checked one edge after the request that moves them.
    stretch_hold_a: assert property (state == ST_STRETCH
        |-> local_scl_oe_out && !local_scl_out)
        else $error("local clock not held during forward");
    scl_idle_a: assert property (state == ST_IDLE |=> remote_scl_out)
        else $error("remote clock not idle high");
    scl_reload_a: assert property (state == ST_STRETCH && scl_cnt == 12'h0000
        |=> scl_cnt == (HALF_SLOW >> $past(rate_reg[2:0])))
        else $error("remote clock half period wrong");
    xlate_a: assert property (state == ST_IDLE && fwd_addr_valid_in
        && fwd_addr_in[7:1] == src_a[7:1]
        |=> remote_addr_out == {$past(dst_a[7:1]), $past(fwd_addr_in[0])})
        else $error("address not translated");
    xlate_b_a: assert property (state == ST_IDLE && fwd_addr_valid_in
        && fwd_addr_in[7:1] != src_a[7:1] && fwd_addr_in[7:1] == src_b[7:1]
        |=> remote_addr_out == {$past(dst_b[7:1]), $past(fwd_addr_in[0])})
        else $error("second address not translated");
    xlate_pass_a: assert property (state == ST_IDLE && fwd_addr_valid_in
        && fwd_addr_in[7:1] != src_a[7:1] && fwd_addr_in[7:1] != src_b[7:1]
        |=> remote_addr_out == $past(fwd_addr_in))
        else $error("unmatched address altered");
    no_arb_a: assert property (state == ST_STRETCH && !remote_done_in
        |=> $stable(remote_addr_out) && state == ST_STRETCH)
        else $error("busy forward disturbed");
    relay_delay_a: assert property ((gpi_s3 != gpi_s2)
        |=> relay_strobe_out && relay_level_out == $past(gpi_s2))
        else $error("input change not relayed");
    relay_reset_a: assert property ($past(rst_in) |-> !relay_level_out)
        else $error("relay output not low after reset");
    gpi_read_a: assert property (reg_rd_in && reg_addr_in == OFS_INPUT
        |=> reg_rdata_out[GPI_BIT] == $past(gpi_s2) && reg_rdata_out[3:0] == 4'h0)
        else $error("input state read wrong");
    eq_reset_a: assert property ($past(rst_in) |-> eq_reg == RST_EQ && !eq_en_out)
        else $error("equalizer power-up state wrong");
    eq_boost_a: assert property (eq_boost_out <= EQ_MAX
        && (eq_reg[3:0] > EQ_MAX || eq_boost_out == eq_reg[3:0]))
        else $error("boost level out of range");
    chk_en_a: assert property (reg_wr_in && reg_addr_in == OFS_TEST
        |=> checker_en_out == $past(reg_wdata_in[CHK_BIT]))
        else $error("checker enable not written");
    rate_wr_a: assert property (reg_wr_in && reg_addr_in == OFS_RATE
        |=> rate_reg == $past(reg_wdata_in))
        else $error("rate field not written");
    spread_dec_a: assert property (spread_on_out == ss[0]
        && spread_wide_out == (ss == SS_FOUR))
        else $error("spread code decode wrong");
    manual_div_a: assert property (sawtooth_divider_reg[5:0] != 6'h00
        |-> sawtooth_div_out == sawtooth_divider_reg[5:0])
        else $error("manual divider ignored");
    // The automatic choice must stay inside the limit of the active spread setting.
    auto_div_a: assert property (sawtooth_divider_reg[5:0] == 6'h00
        |-> sawtooth_div_out != 6'h00
        && sawtooth_div_out <= (spread_wide_out ? SAWTOOTH_DIVIDER_MAX_FOUR : SAWTOOTH_DIVIDER_MAX_TWO))
        else $error("automatic divider out of range");
    tick_a: assert property (mod_tick_out |=> !mod_tick_out)
        else $error("modulation tick too long");
    tick_off_a: assert property (!spread_on_out |=> !mod_tick_out)
        else $error("modulation tick without spread");

    fwd_c: cover property (state == ST_IDLE && fwd_addr_valid_in ##[1:300] remote_done_in);
    relay_c: cover property (relay_strobe_out && relay_level_out);
    tick_c: cover property (mod_tick_out && data_rate_select_in);
    xlate_c: cover property (state == ST_IDLE && fwd_addr_valid_in
        && fwd_addr_in[7:1] == src_b[7:1]);
endmodule : dcc_top

// *** tb/dcc_remote_model.sv ***
`timescale 1ns/1ps
module dcc_remote_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Forward request and chosen answer delay
    input wire logic req_in,
    input wire logic [7:0] wait_in,
    // Completion back to the block
    output logic done_out
);
    int cnt;
    // A slow answer keeps the local clock stretched for as long as it lasts.
    always_ff @(posedge clk_in) begin
        if (rst_in || !req_in) begin
            cnt <= 0;
            done_out <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            done_out <= (cnt == int'(wait_in));
        end
    end
endmodule : dcc_remote_model

// *** tb/test_deser_ctrl_channel_config.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module test_deser_ctrl_channel_config;
    import dcc_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, fv = 0, relay_input = 0, data_rate_select = 0, done;
    logic [7:0] addr = 0, wdata = 0, fa = 0, pw = 8'h64, d, rdata, raddr;
    logic [1:0] rng = 0;
    logic lscl, scl_oe, req, rscl, lvl, stb, chk, eqe, son, swide, tick;
    logic [3:0] boost;
    logic [5:0] sawtooth_divider;
    logic [31:0] seed = 32'he656_d3f4;
    int mismatches = 0, n_compared = 0, n;
    int regs[16];
    always #12.5 clk = ~clk;
    dcc_top uut (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .fwd_addr_valid_in(fv),
        .fwd_addr_in(fa), .remote_done_in(done), .local_scl_out(lscl),
        .local_scl_oe_out(scl_oe), .remote_req_out(req), .remote_addr_out(raddr),
        .remote_scl_out(rscl), .relay_input_in(relay_input), .relay_level_out(lvl),
        .relay_strobe_out(stb), .data_rate_select_in(data_rate_select), .pclk_range_in(rng),
        .checker_en_out(chk), .eq_en_out(eqe), .eq_boost_out(boost), .spread_on_out(son),
        .spread_wide_out(swide), .sawtooth_div_out(sawtooth_divider), .mod_tick_out(tick));
    dcc_remote_model far (.clk_in(clk), .rst_in(rst), .req_in(req), .wait_in(pw),
        .done_out(done));
    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd8
    function automatic logic [7:0] mdl(int a);
        return (a == 14) ? {3'b0, relay_input, 4'b0} : 8'(regs[a]);
    endfunction : mdl
    function automatic logic [7:0] xl(logic [7:0] a);
        if (a[7:1] == regs[9][7:1]) return {regs[10][7:1], a[0]};
        if (a[7:1] == regs[11][7:1]) return {regs[12][7:1], a[0]};
        return a;
    endfunction : xl
    task automatic cyc(int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wreg(logic [7:0] a, logic [7:0] v);
        addr = a;
        wdata = v;
        wr = 1;
        cyc();
        wr = 0;
        cyc();
        if (a inside {[3:5], [9:13]}) regs[a] = v;
    endtask : wreg
    task automatic rreg(logic [7:0] a, output logic [7:0] v);
        addr = a;
        rd = 1;
        cyc();
        rd = 0;
        v = rdata;
        cyc();
    endtask : rreg
    task automatic fwd(logic [7:0] a);
        int m, t0, per;
        logic ps;
        m = 0;
        t0 = 0;
        per = 0;
        ps = 1'b1;
        fa = a;
        fv = 1;
        cyc();
        fa = ~a;
        cyc();
        fv = 0;
        cyc();
        `CHK(scl_oe, 1'b1)
        `CHK(req, 1'b1)
        `CHK(lscl, 1'b0)
        `CHK(raddr, xl(a))
        while (scl_oe === 1'b1 && m < 600) begin
            cyc();
            m++;
            if (rscl !== ps && t0 > 0 && per == 0) per = m - t0;
            if (rscl !== ps) t0 = m;
            ps = rscl;
        end
        if (per > 0) `CHK(per, (2000 >> regs[13][2:0]) + 1)
        `CHK(scl_oe, 1'b0)
        `CHK(m, int'(pw))
        // The remote clock may end the transfer low; it returns high one edge later.
        cyc();
        `CHK(rscl, 1'b1)
    endtask : fwd
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial begin
        // The tests need about 50000 cycles; the limit leaves room above that.
        #(25 * 80000);
        mismatches++;
        wrap_up();
    end
    initial begin
        for (int i = 0; i < 16; i++) regs[i] = 0;
        regs[5] = 9;
        cyc(4);
        rst = 0;
        for (int a = 0; a < 16; a++) begin
            rreg(a[7:0], d);
            `CHK(d, mdl(a))
        end
        `CHK(eqe, 1'b0)
        `CHK(boost, 4'h9)
        `CHK(lvl, 1'b0)
        `CHK(son, 1'b0)
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            for (int a = 9; a < 13; a++) wreg(a[7:0], rnd8());
            wreg(8'h0D, 8'(7 - k % 4));
            wreg(8'h0E, rnd8());
            for (int a = 9; a < 15; a++) begin
                rreg(a[7:0], d);
                `CHK(d, mdl(a))
            end
            d = (k % 3 == 0) ? 8'(regs[9]) : (k % 3 == 1) ? 8'(regs[11]) : rnd8();
            d[0] = k[1];
            pw = 8'(100 + rnd8() % 150);
            fwd(d);
        end
        $display("test forwarding done");
        for (int k = 0; k < 3; k++) begin
            relay_input = ~relay_input;
            n = 0;
            while (stb !== 1'b1 && n < 14000) begin
                cyc();
                n++;
            end
            `CHK(n <= 3, 1'b1)
            `CHK(lvl, relay_input)
            rreg(8'h0E, d);
            `CHK(d, mdl(14))
            // Transitions are kept a full relay delay apart, as the pin source must.
            cyc(14000);
        end
        $display("test relay done");
        for (int c = 0; c < 32; c++) begin
            wreg(8'h05, 8'(c));
            wreg(8'h04, {2'b0, c[0], 5'b0});
            `CHK(boost, (c[3:0] > 4'hB) ? 4'hB : c[3:0])
            `CHK(eqe, c[4])
            `CHK(chk, c[0])
        end
        $display("test equalizer done");
        for (int c = 0; c < 16; c++) begin
            rng = c[1:0];
            wreg(8'h03, {c[3:2], 6'h00});
            `CHK(son, c[2])
            `CHK(swide, c[3:2] == 2'b11)
            `CHK(sawtooth_divider, (c[1:0] == 2'b11) ? 6'h0F : 6'h02 << c[1:0])
        end
        for (int k = 1; k < 4; k++) begin
            data_rate_select = k[0];
            wreg(8'h03, {2'b01, k[5:0]});
            `CHK(sawtooth_divider, k[5:0])
            for (int j = 0; j < 3; j++) begin
                n = 0;
                do begin
                    cyc();
                    n++;
                end while (tick !== 1'b1 && n < 1000);
            end
            `CHK(n, (int'(MOD_COEF) * k) >> k[0])
        end
        $display("test spread done");
        wrap_up();
    end
endmodule : test_deser_ctrl_channel_config
